// *** flash_ctrl_pkg.sv ***
package flash_ctrl_pkg;
  // opcodes handled by the front-end
  localparam logic [7:0] OP_WR_EN = 8'h06;
  localparam logic [7:0] OP_WR_DIS = 8'h04;
  localparam logic [7:0] OP_WR_ST1 = 8'h01;
  localparam logic [7:0] OP_WR_ST2 = 8'h31;
  localparam logic [7:0] OP_WR_ST3 = 8'h11;
  localparam logic [7:0] OP_RD_ST2 = 8'h35;
  localparam logic [7:0] OP_RD_ST3 = 8'h15;
  localparam logic [7:0] OP_RD_EXT = 8'hc8;
  localparam logic [7:0] OP_WR_EXT = 8'hc5;
  localparam logic [7:0] OP_PAUSE = 8'h75;
  localparam logic [7:0] OP_RESUME = 8'h7a;
  localparam logic [7:0] OP_RST_ARM = 8'h66;
  localparam logic [7:0] OP_RST_GO = 8'h99;
  localparam logic [7:0] OP_CLR_ERR = 8'h30;
  localparam logic [7:0] OP_ENTER_4B = 8'hb7;
  localparam logic [7:0] OP_EXIT_4B = 8'he9;
  localparam logic [7:0] OP_SLEEP = 8'hb9;
  localparam logic [7:0] OP_CHIP_ER0 = 8'h60;
  localparam logic [7:0] OP_CHIP_ER1 = 8'hc7;
  // bit positions in status_config_two
  localparam int B_ADDR_NOW = 0;
  localparam int B_QUAD = 1;
  localparam int B_PROG_PAUSE = 2;
  localparam int B_LOCK_LO = 3;
  localparam int B_PROT_HI = 6;
  localparam int B_ERASE_PAUSE = 7;
  // bit positions in status_config_three
  localparam int B_PROG_FAIL = 2;
  localparam int B_ERASE_FAIL = 3;
  localparam int B_ADDR_BOOT = 4;
  localparam int B_DRV_LO = 5;
  localparam int B_HOLD_RST = 7;
  // reset values of the stored configuration
  localparam logic [1:0] DRV_RST = 2'h1;
  localparam logic ADDR_BOOT_RST = 1'h0;
  localparam logic [2:0] LOCK_RST = 3'h0;
  // address lengths in bytes
  localparam logic [2:0] ALEN_3 = 3'h3;
  localparam logic [2:0] ALEN_4 = 3'h4;

  // commands that always carry a four-byte address
  function automatic logic is_four(input logic [7:0] op);
    case (op)
      8'h13, 8'h0c, 8'h3c, 8'h6c, 8'hbc, 8'hec, 8'h12, 8'h34, 8'h21, 8'h5c, 8'hdc: is_four = 1'h1;
      default: is_four = 1'h0;
    endcase
  endfunction

  function automatic logic is_read(input logic [7:0] op);
    case (op)
      8'h03, 8'h0b, 8'h3b, 8'h6b, 8'hbb, 8'heb, 8'h13, 8'h0c, 8'h3c, 8'h6c, 8'hbc, 8'hec:
        is_read = 1'h1;
      default: is_read = 1'h0;
    endcase
  endfunction

  function automatic logic is_prog(input logic [7:0] op);
    is_prog = (op == 8'h02) || (op == 8'h12) || (op == 8'h32) || (op == 8'h34);
  endfunction

  function automatic logic is_erase(input logic [7:0] op);
    case (op)
      8'h20, 8'h21, 8'h52, 8'h5c, 8'hd8, 8'hdc: is_erase = 1'h1;
      default: is_erase = 1'h0;
    endcase
  endfunction
endpackage

// *** link_if.sv ***
`timescale 1ns/1ps
`default_nettype none
// carries bytes from the serial domain and readback words into it
interface link_if;
  logic [7:0] byte_data;
  logic byte_tgl;
  logic mid_byte;
  logic [23:0] rd_word;
  modport rx (output byte_data, output byte_tgl, output mid_byte, input rd_word);
  modport core (input byte_data, input byte_tgl, input mid_byte, output rd_word);
endinterface
`default_nettype wire

// *** spi_link_rx.sv ***
`timescale 1ns/1ps
`default_nettype none
module spi_link_rx (
  // link pins
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic si,
  input wire logic rst_n,
  output logic so,
  output logic so_oe_n,
  // toward the core
  link_if.rx lk
);
  logic [2:0] bit_cnt_reg;
  logic first_reg;
  logic rd_active_reg;
  logic [6:0] shift_reg;
  logic [7:0] op_reg;
  logic [7:0] out_reg;
  logic [23:0] rd_meta_reg;
  logic [23:0] rd_sync_reg;
  logic [7:0] byte_next;
  logic [7:0] op_next;
  logic [7:0] sel_next;

  assign byte_next = {shift_reg, si};
  assign op_next = first_reg ? byte_next : op_reg;

  ////////////////////////////////////////////////////////////////
  // readback choice, rd word order: two, three, extended
  always_comb begin
    case (op_next)
      flash_ctrl_pkg::OP_RD_ST2: sel_next = rd_sync_reg[7:0];
      flash_ctrl_pkg::OP_RD_ST3: sel_next = rd_sync_reg[15:8];
      flash_ctrl_pkg::OP_RD_EXT: sel_next = rd_sync_reg[23:16];
      default: sel_next = 8'h00;
    endcase
  end

  // frame counter, cleared by the frame's own select so no edge is needed
  always_ff @(posedge sclk or posedge cs_n) begin
    if (cs_n) begin
      bit_cnt_reg <= 3'h0; // R24
      first_reg <= 1'h1;
      rd_active_reg <= 1'h0; // R20
    end else begin
      bit_cnt_reg <= bit_cnt_reg + 3'h1;
      if (bit_cnt_reg == 3'h7) begin
        first_reg <= 1'h0;
        if (first_reg) begin
          rd_active_reg <= (byte_next == flash_ctrl_pkg::OP_RD_ST2) ||
                           (byte_next == flash_ctrl_pkg::OP_RD_ST3) ||
                           (byte_next == flash_ctrl_pkg::OP_RD_EXT);
        end
      end
    end
  end

  // msb-first capture on rising edges
  always_ff @(posedge sclk or negedge rst_n) begin
    if (!rst_n) begin
      shift_reg <= 7'h00;
      lk.byte_data <= 8'h00;
      lk.byte_tgl <= 1'h0;
      lk.mid_byte <= 1'h0;
      op_reg <= 8'h00;
      out_reg <= 8'h00;
    end else begin
      shift_reg <= byte_next[6:0]; // R19
      lk.mid_byte <= (bit_cnt_reg != 3'h7); // R21
      if (bit_cnt_reg == 3'h7) begin
        lk.byte_data <= byte_next;
        lk.byte_tgl <= ~lk.byte_tgl;
        op_reg <= op_next;
        out_reg <= sel_next;
      end
    end
  end

  // readback words are quasi-static, two stages settle during the opcode
  always_ff @(posedge sclk or negedge rst_n) begin
    if (!rst_n) begin
      rd_meta_reg <= 24'h000000;
      rd_sync_reg <= 24'h000000;
    end else begin
      rd_meta_reg <= lk.rd_word;
      rd_sync_reg <= rd_meta_reg;
    end
  end

  // data leaves on falling edges so the host samples on rising ones
  always_ff @(negedge sclk or negedge rst_n) begin
    if (!rst_n) begin
      so <= 1'h0;
    end else begin
      so <= out_reg[3'h7 - bit_cnt_reg];
    end
  end

  assign so_oe_n = ~(rd_active_reg & ~cs_n);
endmodule
`default_nettype wire

// *** flash_status_addr_ctrl.sv ***
`timescale 1ns/1ps
`default_nettype none
// Operation
// R1: lock-down protect code clears on power cycle
// R2: quad bit low keeps pin functions
// R3: lock bits only set, never clear; the code resets them to LOCK_RST on RST_N
// R4: pause command flags erase or program
// R5: resume, software reset, power clear pause flags
// R6: drive field selects read output strength
// R7: select bit picks hold or reset
// R8: quad mode disables hold and reset
// R9: host writes zero to reserved bits
// R10: failures and protected targets set error flags
// R11: clear command clears both error flags
// R12: address-mode bit shows three or four bytes
// R13: boot address bit read only at init
// R14: three-byte mode takes upper bit from register
// R15: upper bit written by extended write
// R16: four-byte mode ignores stored upper bit
// R17: four-byte address overwrites stored upper bit
// R18: dedicated four-byte reads ignore stored bit
// R19: opcode shifted msb first on rising edges
// R20: select high ends frame, deselects output
// R21: write-type commands need whole bytes
// R22: partial program byte: no program, latch kept
// R23: cleared latch refuses writes, program, erase; the code takes the extended write without the latch
// R24: select high abandons partial command
module flash_status_addr_ctrl (
  // core clock and reset
  input wire logic CLK,
  input wire logic RST_N,
  // serial link
  input wire logic SCLK,
  input wire logic CS_N,
  input wire logic SI,
  output logic SO,
  output logic SO_OE_N,
  // array engine status
  input wire logic ERASE_BUSY,
  input wire logic PROGRAM_BUSY,
  input wire logic PROGRAM_FAIL,
  input wire logic ERASE_FAIL,
  input wire logic TARGET_PROTECTED,
  // array engine requests
  output logic [31:0] ACCESS_ADDR,
  output logic READ_START,
  output logic PROGRAM_START,
  output logic ERASE_START,
  output logic SLEEP_REQ,
  // pin functions and configuration
  output logic QUAD_LINES_ON,
  output logic WP_FN_ON,
  output logic HOLD_FN_ON,
  output logic RESET_FN_ON,
  output logic [1:0] DRIVE_SEL,
  output logic [2:0] SECURE_LOCK,
  output logic ADDR_MODE_NOW,
  output logic UPPER_ADDR_BIT
);
  link_if lk ();

  logic cs_meta_reg, cs_sync_reg, cs_last_reg, cs_prev_reg;
  logic tg_meta_reg, tg_sync_reg, tg_last_reg;
  logic md_meta_reg, md_sync_reg;
  logic [2:0] idx_reg;
  logic [7:0] op_reg, d1_reg, d2_reg;
  logic [31:0] addr_reg;
  logic boot_pending_reg, rst_armed_reg;
  logic write_unlock_latch_reg;
  logic protect_mode_lo_reg, protect_mode_hi_reg;
  logic quad_lines_on_reg, hold_rst_sel_reg;
  logic [2:0] secure_lock_reg;
  logic erase_paused_flag_reg, program_paused_flag_reg;
  logic program_fail_flag_reg, erase_fail_flag_reg;
  logic addr_mode_now_reg, addr_mode_at_boot_reg;
  logic [1:0] drive_sel_reg;
  logic upper_addr_bit_reg;
  logic byte_ev, frame_start, frame_end, whole, cmd_ok;
  logic four, sr_write_ok, sw_reset, addr_last;
  logic [2:0] alen;
  logic [31:0] addr_next;
  logic prog_go, erase_go, chip_go;

  ////////////////////////////////////////////////////////////////
  // serial-domain receiver
  spi_link_rx u_rx (
    .sclk(SCLK),
    .cs_n(CS_N),
    .si(SI),
    .rst_n(RST_N),
    .so(SO),
    .so_oe_n(SO_OE_N),
    .lk(lk)
  );

  // readback words, reserved bits read zero
  assign lk.rd_word = {7'h00, upper_addr_bit_reg,
                       hold_rst_sel_reg, drive_sel_reg, addr_mode_at_boot_reg,
                       erase_fail_flag_reg, program_fail_flag_reg, 2'h0,
                       erase_paused_flag_reg, protect_mode_hi_reg, secure_lock_reg,
                       program_paused_flag_reg, quad_lines_on_reg, addr_mode_now_reg};

  ////////////////////////////////////////////////////////////////
  // crossings: select as a level, bytes by toggle
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      cs_meta_reg <= 1'h1;
      cs_sync_reg <= 1'h1;
      cs_last_reg <= 1'h1;
      cs_prev_reg <= 1'h1;
      tg_meta_reg <= 1'h0;
      tg_sync_reg <= 1'h0;
      tg_last_reg <= 1'h0;
      md_meta_reg <= 1'h0;
      md_sync_reg <= 1'h0;
    end else begin
      cs_meta_reg <= CS_N;
      cs_sync_reg <= cs_meta_reg;
      cs_last_reg <= cs_sync_reg;
      cs_prev_reg <= cs_last_reg;
      tg_meta_reg <= lk.byte_tgl;
      tg_sync_reg <= tg_meta_reg;
      tg_last_reg <= tg_sync_reg;
      md_meta_reg <= lk.mid_byte;
      md_sync_reg <= md_meta_reg;
    end
  end

  assign byte_ev = tg_sync_reg ^ tg_last_reg;
  assign frame_start = ~cs_sync_reg & cs_last_reg;
  // one stage behind the byte toggle, so a closing byte counts first
  assign frame_end = cs_last_reg & ~cs_prev_reg;
  // mid-byte level is frozen once the clock stops; an empty frame must not replay op_reg
  assign whole = ~md_sync_reg & (idx_reg != 3'h0);
  assign cmd_ok = frame_end & whole; // R21 R22
  assign four = addr_mode_now_reg | flash_ctrl_pkg::is_four(op_reg); // R16 R18
  assign alen = four ? flash_ctrl_pkg::ALEN_4 : flash_ctrl_pkg::ALEN_3;
  assign addr_last = byte_ev && (idx_reg == alen) &&
                     (flash_ctrl_pkg::is_read(op_reg) || flash_ctrl_pkg::is_prog(op_reg) ||
                      flash_ctrl_pkg::is_erase(op_reg));
  // three-byte commands borrow the stored upper bit
  assign addr_next = four ? {addr_reg[23:0], lk.byte_data} :
                     {7'h00, upper_addr_bit_reg, addr_reg[15:0], lk.byte_data}; // R14
  // lock-down and one-time codes both block status writes
  assign sr_write_ok = write_unlock_latch_reg & ~protect_mode_hi_reg; // R23
  assign sw_reset = cmd_ok && (op_reg == flash_ctrl_pkg::OP_RST_GO) && rst_armed_reg;
  assign prog_go = cmd_ok && flash_ctrl_pkg::is_prog(op_reg) && (idx_reg > alen);
  assign chip_go = (op_reg == flash_ctrl_pkg::OP_CHIP_ER0) ||
                   (op_reg == flash_ctrl_pkg::OP_CHIP_ER1);
  assign erase_go = cmd_ok && ((flash_ctrl_pkg::is_erase(op_reg) && (idx_reg > alen)) ||
                               (chip_go && (idx_reg == 3'h1)));

  ////////////////////////////////////////////////////////////////
  // byte collection within a frame
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      idx_reg <= 3'h0;
      op_reg <= 8'h00;
      d1_reg <= 8'h00;
      d2_reg <= 8'h00;
      addr_reg <= 32'h00000000;
    end else if (frame_start) begin
      idx_reg <= 3'h0; // R24
    end else if (byte_ev) begin
      if (idx_reg != 3'h7) begin
        idx_reg <= idx_reg + 3'h1;
      end
      if (idx_reg == 3'h0) begin
        op_reg <= lk.byte_data; // R19
      end
      if (idx_reg == 3'h1) begin
        d1_reg <= lk.byte_data;
      end
      if (idx_reg == 3'h2) begin
        d2_reg <= lk.byte_data;
      end
      addr_reg <= {addr_reg[23:0], lk.byte_data};
    end
  end

  // requests toward the array engine
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      ACCESS_ADDR <= 32'h00000000;
      READ_START <= 1'h0;
      PROGRAM_START <= 1'h0;
      ERASE_START <= 1'h0;
      SLEEP_REQ <= 1'h0;
    end else begin
      if (addr_last) begin
        ACCESS_ADDR <= addr_next;
      end
      READ_START <= addr_last && flash_ctrl_pkg::is_read(op_reg);
      PROGRAM_START <= prog_go && write_unlock_latch_reg && !TARGET_PROTECTED; // R23
      ERASE_START <= erase_go && write_unlock_latch_reg && !TARGET_PROTECTED;
      SLEEP_REQ <= cmd_ok && (op_reg == flash_ctrl_pkg::OP_SLEEP) && (idx_reg == 3'h1);
    end
  end

  ////////////////////////////////////////////////////////////////
  // write unlock latch and the reset arming
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      write_unlock_latch_reg <= 1'h0;
      rst_armed_reg <= 1'h0;
    end else begin
      if (cmd_ok) begin
        rst_armed_reg <= (op_reg == flash_ctrl_pkg::OP_RST_ARM) && (idx_reg == 3'h1);
      end
      if (sw_reset) begin
        write_unlock_latch_reg <= 1'h0;
      end else if (cmd_ok && (idx_reg == 3'h1) && (op_reg == flash_ctrl_pkg::OP_WR_EN)) begin
        write_unlock_latch_reg <= 1'h1;
      end else if (cmd_ok && (idx_reg == 3'h1) && (op_reg == flash_ctrl_pkg::OP_WR_DIS)) begin
        write_unlock_latch_reg <= 1'h0;
      end else if (prog_go || erase_go) begin
        write_unlock_latch_reg <= 1'h0; // R22
      end else if (cmd_ok && (idx_reg > 3'h1) && (op_reg == flash_ctrl_pkg::OP_WR_ST1 ||
                   op_reg == flash_ctrl_pkg::OP_WR_ST2 ||
                   op_reg == flash_ctrl_pkg::OP_WR_ST3)) begin
        write_unlock_latch_reg <= 1'h0;
      end
    end
  end

  // stored configuration: protect, quad, locks, drive, hold select, boot mode
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      protect_mode_lo_reg <= 1'h0; // R1
      protect_mode_hi_reg <= 1'h0; // R1
      quad_lines_on_reg <= 1'h0;
      secure_lock_reg <= flash_ctrl_pkg::LOCK_RST;
      hold_rst_sel_reg <= 1'h0;
      drive_sel_reg <= flash_ctrl_pkg::DRV_RST;
      addr_mode_at_boot_reg <= flash_ctrl_pkg::ADDR_BOOT_RST;
    end else if (cmd_ok && sr_write_ok) begin
      if (op_reg == flash_ctrl_pkg::OP_WR_ST1 && idx_reg > 3'h1) begin
        protect_mode_lo_reg <= d1_reg[7];
      end
      if ((op_reg == flash_ctrl_pkg::OP_WR_ST2 && idx_reg > 3'h1) ||
          (op_reg == flash_ctrl_pkg::OP_WR_ST1 && idx_reg > 3'h2)) begin
        quad_lines_on_reg <= (op_reg == flash_ctrl_pkg::OP_WR_ST2) ?
                             d1_reg[flash_ctrl_pkg::B_QUAD] : d2_reg[flash_ctrl_pkg::B_QUAD];
        protect_mode_hi_reg <= (op_reg == flash_ctrl_pkg::OP_WR_ST2) ?
                               d1_reg[flash_ctrl_pkg::B_PROT_HI] :
                               d2_reg[flash_ctrl_pkg::B_PROT_HI];
        secure_lock_reg <= secure_lock_reg | ((op_reg == flash_ctrl_pkg::OP_WR_ST2) ?
                           d1_reg[flash_ctrl_pkg::B_LOCK_LO +: 3] :
                           d2_reg[flash_ctrl_pkg::B_LOCK_LO +: 3]); // R3
      end
      if (op_reg == flash_ctrl_pkg::OP_WR_ST3 && idx_reg > 3'h1) begin
        hold_rst_sel_reg <= d1_reg[flash_ctrl_pkg::B_HOLD_RST];
        drive_sel_reg <= d1_reg[flash_ctrl_pkg::B_DRV_LO +: 2];
        addr_mode_at_boot_reg <= d1_reg[flash_ctrl_pkg::B_ADDR_BOOT];
      end
    end
  end

  ////////////////////////////////////////////////////////////////
  // address mode and the stored upper address bit
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      boot_pending_reg <= 1'h1;
      addr_mode_now_reg <= 1'h0;
      upper_addr_bit_reg <= 1'h0;
    end else begin
      boot_pending_reg <= 1'h0;
      if (boot_pending_reg || sw_reset) begin
        addr_mode_now_reg <= addr_mode_at_boot_reg; // R13
        upper_addr_bit_reg <= 1'h0;
      end else begin
        if (cmd_ok && idx_reg == 3'h1 && op_reg == flash_ctrl_pkg::OP_ENTER_4B) begin
          addr_mode_now_reg <= 1'h1; // R12
        end
        if (cmd_ok && idx_reg == 3'h1 && op_reg == flash_ctrl_pkg::OP_EXIT_4B) begin
          addr_mode_now_reg <= 1'h0; // R12
        end
        if (addr_last && four) begin
          upper_addr_bit_reg <= addr_next[24]; // R17
        end else if (cmd_ok && idx_reg > 3'h1 && op_reg == flash_ctrl_pkg::OP_WR_EXT) begin
          upper_addr_bit_reg <= d1_reg[0]; // R15
        end
      end
    end
  end

  // pause flags and error flags, a new event beats a clear
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      erase_paused_flag_reg <= 1'h0;
      program_paused_flag_reg <= 1'h0;
      program_fail_flag_reg <= 1'h0;
      erase_fail_flag_reg <= 1'h0;
    end else begin
      if (cmd_ok && op_reg == flash_ctrl_pkg::OP_PAUSE) begin
        erase_paused_flag_reg <= erase_paused_flag_reg | ERASE_BUSY; // R4
        program_paused_flag_reg <= program_paused_flag_reg | (PROGRAM_BUSY & ~ERASE_BUSY);
      end else if (sw_reset || (cmd_ok && op_reg == flash_ctrl_pkg::OP_RESUME)) begin
        erase_paused_flag_reg <= 1'h0; // R5
        program_paused_flag_reg <= 1'h0; // R5
      end
      if (PROGRAM_FAIL || (prog_go && write_unlock_latch_reg && TARGET_PROTECTED)) begin
        program_fail_flag_reg <= 1'h1; // R10
      end else if (cmd_ok && op_reg == flash_ctrl_pkg::OP_CLR_ERR) begin
        program_fail_flag_reg <= 1'h0; // R11
      end
      if (ERASE_FAIL || (erase_go && write_unlock_latch_reg && TARGET_PROTECTED)) begin
        erase_fail_flag_reg <= 1'h1; // R10
      end else if (cmd_ok && op_reg == flash_ctrl_pkg::OP_CLR_ERR) begin
        erase_fail_flag_reg <= 1'h0; // R11
      end
    end
  end

  ////////////////////////////////////////////////////////////////
  // pin functions follow the quad and hold-select bits
  assign QUAD_LINES_ON = quad_lines_on_reg; // R2
  assign WP_FN_ON = ~quad_lines_on_reg; // R2
  assign HOLD_FN_ON = ~quad_lines_on_reg & ~hold_rst_sel_reg; // R7 R8
  assign RESET_FN_ON = ~quad_lines_on_reg & hold_rst_sel_reg; // R7 R8
  assign DRIVE_SEL = drive_sel_reg; // R6
  assign SECURE_LOCK = secure_lock_reg;
  assign ADDR_MODE_NOW = addr_mode_now_reg;
  assign UPPER_ADDR_BIT = upper_addr_bit_reg;

  ////////////////////////////////////////////////////////////////
  // checks
  default clocking @(posedge CLK); endclocking
  default disable iff (!RST_N);

  a_lock_sticky: assert property (|$past(secure_lock_reg) |-> // R3
    (($past(secure_lock_reg) & ~secure_lock_reg) == 3'h0)) else $error("lock bit cleared");
  a_latch_refuse: assert property (PROGRAM_START |-> $past(write_unlock_latch_reg)) // R23
    else $error("program without unlock latch");
  a_partial_keep: assert property (frame_end && md_sync_reg && idx_reg != 3'h0 && // R22
    write_unlock_latch_reg |=> write_unlock_latch_reg && !PROGRAM_START)
    else $error("partial byte disturbed latch");
  a_err_clear: assert property (cmd_ok && op_reg == flash_ctrl_pkg::OP_CLR_ERR && // R11
    !PROGRAM_FAIL && !prog_go |=> !program_fail_flag_reg) else $error("error flag kept");
  a_err_set: assert property (PROGRAM_FAIL |=> program_fail_flag_reg) // R10
    else $error("program failure not flagged");
  a_pause_clear: assert property (cmd_ok && op_reg == flash_ctrl_pkg::OP_RESUME |=> // R5
    !erase_paused_flag_reg && !program_paused_flag_reg) else $error("pause flag kept");
  a_quad_pins: assert property (quad_lines_on_reg |-> // R8
    !HOLD_FN_ON && !RESET_FN_ON && !WP_FN_ON) else $error("pin function in quad mode");
  a_upper_4b: assert property (addr_last && four |=> // R17
    upper_addr_bit_reg == ACCESS_ADDR[24]) else $error("upper bit not replaced");
  a_addr_3b: assert property (addr_last && !four ##1 READ_START |-> // R14
    ACCESS_ADDR[31:24] == {7'h00, $past(upper_addr_bit_reg)}) else $error("upper bit lost");
  a_boot_mode: assert property ($rose(RST_N) ##1 1'h1 |-> // R13
    addr_mode_now_reg == $past(addr_mode_at_boot_reg)) else $error("boot mode not taken");
endmodule
`default_nettype wire

// *** spi_host_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module spi_host_model (
  // link pins
  output logic sclk,
  output logic cs_n,
  output logic si,
  input wire logic so
);
  // idle host: clock parked low, nothing selected
  initial begin
    sclk = 1'h0;
    cs_n = 1'h1;
    si = 1'h0;
  end

  ////////////////////////////////////////////////////////////////////////
  // one frame: last n bits of w go out msb first, last 8 returned bits in rd
  // the link clock only runs inside the frame, 6 ns period
  task automatic frame(input logic [47:0] w, input int n, output logic [7:0] rd);
    rd = 8'h00;
    cs_n = 1'h0;
    #5;
    for (int i = n - 1; i >= 0; i--) begin
      si = w[i];
      #3 sclk = 1'h1;
      rd = {rd[6:0], so};
      #3 sclk = 1'h0;
    end
    // stopping at any bit count is allowed; the device must judge it
    #3 cs_n = 1'h1;
    // released line: no stale value left on it
    si = ~si;
    #100;
  endtask
endmodule
`default_nettype wire

// *** flash_status_addr_ctrl_tb.sv ***
`timescale 1ns/1ps
`default_nettype none
module flash_status_addr_ctrl_tb;
  logic CLK, RST_N, SCLK, CS_N, SI, SO, SO_OE_N, READ_START, PROGRAM_START, ERASE_START;
  logic ERASE_BUSY, PROGRAM_BUSY, PROGRAM_FAIL, ERASE_FAIL, TARGET_PROTECTED, SLEEP_REQ;
  logic QUAD_LINES_ON, WP_FN_ON, HOLD_FN_ON, RESET_FN_ON, ADDR_MODE_NOW, UPPER_ADDR_BIT;
  logic [31:0] ACCESS_ADDR, v;
  logic [1:0] DRIVE_SEL;
  logic [2:0] SECURE_LOCK;
  logic [7:0] rd;
  int fail_count = 0;
  int compares = 0;
  int seed = 32'hdd7b;
  int n_rd = 0, n_pg = 0, n_er = 0, n_sl = 0, n_oe = 0;

  flash_status_addr_ctrl uut (.CLK, .RST_N, .SCLK, .CS_N, .SI, .SO, .SO_OE_N, .ERASE_BUSY,
    .PROGRAM_BUSY, .PROGRAM_FAIL, .ERASE_FAIL, .TARGET_PROTECTED, .ACCESS_ADDR, .READ_START,
    .PROGRAM_START, .ERASE_START, .SLEEP_REQ, .QUAD_LINES_ON, .WP_FN_ON, .HOLD_FN_ON,
    .RESET_FN_ON, .DRIVE_SEL, .SECURE_LOCK, .ADDR_MODE_NOW, .UPPER_ADDR_BIT);
  spi_host_model host (.sclk(SCLK), .cs_n(CS_N), .si(SI), .so(SO));

  // core clock, 10 ns
  initial CLK = 1'h0;
  always #5 CLK = ~CLK;
  // one-cycle pulses are counted
  always @(posedge CLK) begin
    n_rd <= n_rd + READ_START;
    n_pg <= n_pg + PROGRAM_START;
    n_er <= n_er + ERASE_START;
    n_sl <= n_sl + SLEEP_REQ;
  end
  // drive window seen at falling edges
  always @(negedge SCLK) n_oe <= n_oe + !SO_OE_N;

  ////////////////////////////////////////////////////////////////////////
  // compare and count
  task automatic check(input logic [32:0] got, input logic [32:0] exp);
    compares++;
    if (got !== exp) begin
      fail_count++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  // right-aligned frame of n bits
  task automatic cmd(input logic [47:0] w, input int n);
    host.frame(w, n, rd);
  endtask
  // read one register byte and compare
  task automatic rdr(input logic [7:0] op, input logic [7:0] exp);
    int k;
    k = n_oe;
    host.frame({op, 8'h00}, 16, rd);
    check(rd, exp);
    check(n_oe - k, 33'h9);
  endtask
  // expected third status byte, boot bit always 0 here
  function automatic logic [7:0] st3(input logic h, input logic [1:0] d, input logic e, p);
    st3 = {h, d, 1'h0, e, p, 2'h0};
  endfunction
  task automatic conclude;
    $display("compares=%0d fail_count=%0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  // watchdog well beyond the longest expected run
  initial begin
    #300000;
    fail_count++;
    conclude();
  end

  ////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    {RST_N, ERASE_BUSY, PROGRAM_BUSY, PROGRAM_FAIL, ERASE_FAIL, TARGET_PROTECTED} = 6'h0;
    repeat (3) @(posedge CLK);
    RST_N <= 1'h1;
    repeat (4) @(posedge CLK);
    // power-up defaults
    rdr(flash_ctrl_pkg::OP_RD_ST3, st3(1'h0, 2'h1, 1'h0, 1'h0));
    check({WP_FN_ON, HOLD_FN_ON, RESET_FN_ON}, 3'h6);
    rdr(flash_ctrl_pkg::OP_RD_ST2, 8'h00);
    // reset function on the shared pin, full drive
    cmd(flash_ctrl_pkg::OP_WR_EN, 8);
    cmd({flash_ctrl_pkg::OP_WR_ST3, 8'h80}, 16);
    check({HOLD_FN_ON, RESET_FN_ON, DRIVE_SEL}, 4'h4);
    // quad mode overrides the pin choice; one lock bit set
    cmd(flash_ctrl_pkg::OP_WR_EN, 8);
    cmd({flash_ctrl_pkg::OP_WR_ST2, 8'h0a}, 16);
    check({QUAD_LINES_ON, WP_FN_ON, HOLD_FN_ON, RESET_FN_ON, SECURE_LOCK}, 7'h41);
    // frame one bit short is ignored
    cmd(flash_ctrl_pkg::OP_WR_EN, 8);
    cmd({flash_ctrl_pkg::OP_WR_ST2, 7'h01}, 15);
    rdr(flash_ctrl_pkg::OP_RD_ST2, 8'h0a);
    // half a data byte: latch survives for the next write; lock stays set
    cmd({8'h02, 28'h0}, 36);
    cmd({flash_ctrl_pkg::OP_WR_ST2, 8'h00}, 16);
    rdr(flash_ctrl_pkg::OP_RD_ST2, 8'h08);
    check(n_pg, 33'h0);
    cmd(flash_ctrl_pkg::OP_WR_DIS, 8);
    cmd({flash_ctrl_pkg::OP_WR_ST2, 8'h02}, 16);
    rdr(flash_ctrl_pkg::OP_RD_ST2, 8'h08);
    // upper address bit in three- and four-byte modes
    cmd({flash_ctrl_pkg::OP_WR_EXT, 8'h01}, 16);
    rdr(flash_ctrl_pkg::OP_RD_EXT, 8'h01);
    cmd({8'h03, 24'h123456}, 32);
    check(ACCESS_ADDR, 32'h01123456);
    check(n_rd, 33'h1);
    cmd({8'h13, 32'h00abcdef}, 40);
    check({UPPER_ADDR_BIT, ACCESS_ADDR}, 33'h000abcdef);
    cmd(flash_ctrl_pkg::OP_ENTER_4B, 8);
    check(ADDR_MODE_NOW, 1'h1);
    cmd({flash_ctrl_pkg::OP_WR_EXT, 8'h01}, 16);
    cmd({8'h03, 32'h00004321}, 40);
    check(ACCESS_ADDR, 32'h00004321);
    cmd(flash_ctrl_pkg::OP_EXIT_4B, 8);
    // pause flags and their clearing
    @(posedge CLK) ERASE_BUSY <= 1'h1;
    cmd(flash_ctrl_pkg::OP_PAUSE, 8);
    rdr(flash_ctrl_pkg::OP_RD_ST2, 8'h88);
    cmd(flash_ctrl_pkg::OP_RESUME, 8);
    rdr(flash_ctrl_pkg::OP_RD_ST2, 8'h08);
    @(posedge CLK) {ERASE_BUSY, PROGRAM_BUSY} <= 2'h1;
    cmd(flash_ctrl_pkg::OP_PAUSE, 8);
    rdr(flash_ctrl_pkg::OP_RD_ST2, 8'h0c);
    cmd(flash_ctrl_pkg::OP_RST_ARM, 8);
    cmd(flash_ctrl_pkg::OP_RST_GO, 8);
    rdr(flash_ctrl_pkg::OP_RD_ST2, 8'h08);
    // error flags from a failure and from a protected target
    @(posedge CLK) {PROGRAM_BUSY, PROGRAM_FAIL} <= 2'h1;
    @(posedge CLK) {PROGRAM_FAIL, TARGET_PROTECTED} <= 2'h1;
    rdr(flash_ctrl_pkg::OP_RD_ST3, st3(1'h1, 2'h0, 1'h0, 1'h1));
    cmd(flash_ctrl_pkg::OP_WR_EN, 8);
    cmd({8'h20, 24'h0}, 32);
    rdr(flash_ctrl_pkg::OP_RD_ST3, st3(1'h1, 2'h0, 1'h1, 1'h1));
    check(n_er, 33'h0);
    cmd(flash_ctrl_pkg::OP_CLR_ERR, 8);
    rdr(flash_ctrl_pkg::OP_RD_ST3, st3(1'h1, 2'h0, 1'h0, 1'h0));
    // unprotected program starts once, the repeat lacks the latch
    @(posedge CLK) TARGET_PROTECTED <= 1'h0;
    cmd(flash_ctrl_pkg::OP_WR_EN, 8);
    cmd({8'h02, 24'h0, 8'h5a}, 40);
    check(n_pg, 33'h1);
    cmd({8'h02, 24'h0, 8'h5a}, 40);
    check(n_pg, 33'h1);
    // random upper bits and addresses, reserved bits kept zero
    for (int i = 0; i < 8; i++) begin
      v = $random(seed);
      cmd({flash_ctrl_pkg::OP_WR_EXT, 7'h0, v[31]}, 16);
      cmd({8'h03, v[23:0]}, 32);
      check(ACCESS_ADDR, {7'h0, v[31], v[23:0]});
      check(n_rd, i + 4);
    end
    // boot bit reloaded by a software reset
    cmd(flash_ctrl_pkg::OP_WR_EN, 8);
    cmd({flash_ctrl_pkg::OP_WR_ST3, 8'h90}, 16);
    cmd(flash_ctrl_pkg::OP_RST_ARM, 8);
    cmd(flash_ctrl_pkg::OP_RST_GO, 8);
    check(ADDR_MODE_NOW, 1'h1);
    cmd(flash_ctrl_pkg::OP_EXIT_4B, 8);
    // sleep only on a whole byte
    cmd({flash_ctrl_pkg::OP_SLEEP, 1'h0}, 9);
    cmd(flash_ctrl_pkg::OP_SLEEP, 8);
    check(n_sl, 33'h1);
    // lock-down code lost over a power cycle
    cmd(flash_ctrl_pkg::OP_WR_EN, 8);
    cmd({flash_ctrl_pkg::OP_WR_ST1, 8'h00, 8'h40}, 24);
    rdr(flash_ctrl_pkg::OP_RD_ST2, 8'h48);
    @(posedge CLK) RST_N <= 1'h0;
    repeat (3) @(posedge CLK);
    RST_N <= 1'h1;
    repeat (4) @(posedge CLK);
    rdr(flash_ctrl_pkg::OP_RD_ST2, 8'h00);
    conclude();
  end
endmodule
`default_nettype wire
